/* File: src/sgc_config_regs.sv */
/*
  General configuration and mode select register slice of the serializer.
  Assumes the local I2C host logic presents one-cycle read and write strobes,
  and that back-channel and forwarding logic share the core clock.
*/
`timescale 1ns/1ns
module sgc_config_regs
  import sgc_pkg::*;
(
  input  wire logic                 MCLK_I,
  input  wire logic                 SYS_RST_I,
  input  wire logic [7:0]           REG_ADDR_I,
  input  wire logic [7:0]           REG_WDATA_I,
  input  wire logic                 REG_WR_I,
  input  wire logic                 REG_RD_I,
  output logic      [7:0]           REG_RDATA_O,
  output logic                      REG_ACK_O,
  input  wire logic                 LINK_LOCK_I,
  input  wire logic                 BC_CRC_ERR_I,
  output logic      [CRC_CNT_W-1:0] CRC_ERR_CNT_O,
  output logic                      CRC_CHECK_EN_O,
  output logic                      PARITY_EN_O,
  input  wire logic                 REM_WR_REQ_I,
  input  wire logic                 REM_WR_TO_DES_I,
  input  wire logic [ID_W-1:0]      REM_WR_ADDR_I,
  output logic                      AUTO_ACK_O,
  output logic                      FWD_O,
  output logic      [ID_W-1:0]      FWD_ADDR_O,
  input  wire logic                 MODE_PIN_I,
  input  wire logic                 PLL_SRC_REG_I,
  output logic                      PLL_SRC_O,
  input  wire logic                 PCLK_I,
  input  wire logic [PIX_W-1:0]     PIX_DATA_I,
  output logic      [PIX_W-1:0]     PIX_O,
  output logic                      PIX_STB_O,
  input  wire logic                 BC_MODE_VALID_I,
  input  wire logic                 BC_MODE12_I,
  input  wire logic                 BC_MODE10_I,
  input  wire logic                 LOCAL_MODE12_I,
  input  wire logic                 LOCAL_MODE10_I,
  output logic                      MODE12_O,
  output logic                      MODE10_O,
  input  wire logic                 BC_DES_ID_VALID_I,
  input  wire logic [ID_W-1:0]      BC_DES_ID_I
);
  logic [7:0]           gen_cfg_r;
  logic                 mode_ovr_r;
  logic                 rem12_r;
  logic                 rem10_r;
  logic                 fresh_r;
  logic [ID_W-1:0]      des_id_r;
  logic                 freeze_r;
  logic [CRC_CNT_W-1:0] crc_cnt_r;
  logic                 lock_s1_r;
  logic                 lock_s;
  logic                 mode_s1_r;
  logic                 mode_s;
  logic [7:0]           rd_nxt;
  logic                 auto_ok;
  logic                 wr_gc;
  logic                 wr_ms;
  logic                 wr_di;

  assign wr_gc = REG_WR_I && (REG_ADDR_I == ADDR_GEN_CFG);
  assign wr_ms = REG_WR_I && (REG_ADDR_I == ADDR_MODE_SEL);
  assign wr_di = REG_WR_I && (REG_ADDR_I == ADDR_DES_ID);

  // Lock and mode pin come from outside the core domain.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      lock_s1_r <= 1'b0;
      lock_s    <= 1'b0;
      mode_s1_r <= 1'b0;
      mode_s    <= 1'b0;
    end else begin
      lock_s1_r <= LINK_LOCK_I;
      lock_s    <= lock_s1_r;
      mode_s1_r <= MODE_PIN_I;
      mode_s    <= mode_s1_r;
    end
  end

  // Writes land in one core cycle and are always acknowledged, so the bus never waits.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      gen_cfg_r  <= GEN_CFG_RST;
      mode_ovr_r <= 1'b0;
    end else begin
      if (wr_gc) begin
        gen_cfg_r <= REG_WDATA_I & GEN_CFG_MASK;
      end
      if (wr_ms) begin
        mode_ovr_r <= REG_WDATA_I[MS_OVERRIDE];
      end
    end
  end

  // Software writes win over a back-channel load in the same cycle.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      des_id_r <= DES_ID_RST[7:1];
      freeze_r <= DES_ID_RST[DI_FREEZE];
    end else if (wr_di) begin
      des_id_r <= REG_WDATA_I[7:1];
      freeze_r <= REG_WDATA_I[DI_FREEZE];
    end else if (BC_DES_ID_VALID_I && lock_s && !freeze_r) begin
      des_id_r <= BC_DES_ID_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      crc_cnt_r <= '0;
    end else if (gen_cfg_r[GC_CRC_CLR]) begin
      crc_cnt_r <= '0;
    end else if (gen_cfg_r[GC_CRC_EN] && BC_CRC_ERR_I && (crc_cnt_r != '1)) begin
      crc_cnt_r <= crc_cnt_r + 1'b1;
    end
  end

  // A report is taken only under lock; one arriving after a lock loss is dropped and fresh_r clears.
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      rem12_r <= 1'b0;
      rem10_r <= 1'b0;
      fresh_r <= 1'b0;
    end else if (BC_MODE_VALID_I && lock_s) begin
      rem12_r <= BC_MODE12_I;
      rem10_r <= BC_MODE10_I;
      fresh_r <= 1'b1;
    end else if (!lock_s) begin
      fresh_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      MODE12_O <= 1'b0;
      MODE10_O <= 1'b0;
    end else begin
      MODE12_O <= mode_ovr_r ? LOCAL_MODE12_I : rem12_r;
      MODE10_O <= mode_ovr_r ? LOCAL_MODE10_I : rem10_r;
    end
  end

  assign auto_ok = gen_cfg_r[GC_AUTO_ACK] && lock_s && gen_cfg_r[GC_FWD_EN] &&
                   (REM_WR_TO_DES_I || gen_cfg_r[GC_PASS_ALL]);

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      AUTO_ACK_O <= 1'b0;
      FWD_O      <= 1'b0;
      FWD_ADDR_O <= '0;
    end else begin
      AUTO_ACK_O <= REM_WR_REQ_I && auto_ok;
      FWD_O      <= REM_WR_REQ_I && gen_cfg_r[GC_FWD_EN];
      if (REM_WR_REQ_I) begin
        FWD_ADDR_O <= REM_WR_TO_DES_I ? des_id_r : REM_WR_ADDR_I;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      PLL_SRC_O      <= 1'b0;
      CRC_CHECK_EN_O <= 1'b0;
      PARITY_EN_O    <= 1'b0;
    end else begin
      PLL_SRC_O      <= gen_cfg_r[GC_PLL_OVR] ? PLL_SRC_REG_I : mode_s;
      CRC_CHECK_EN_O <= gen_cfg_r[GC_CRC_EN];
      PARITY_EN_O    <= gen_cfg_r[GC_PARITY_EN];
    end
  end

  assign CRC_ERR_CNT_O = crc_cnt_r;

  always_comb begin
    rd_nxt = ZERO_BYTE;
    case (REG_ADDR_I)
      ADDR_GEN_CFG: begin
        rd_nxt = gen_cfg_r;
      end
      ADDR_MODE_SEL: begin
        rd_nxt[MS_OVERRIDE] = mode_ovr_r;
        rd_nxt[MS_CURRENT]  = fresh_r;
        rd_nxt[MS_MODE12]   = MODE12_O;
        rd_nxt[MS_MODE10]   = MODE10_O;
      end
      ADDR_DES_ID: begin
        rd_nxt = {des_id_r, freeze_r};
      end
      default: begin
        rd_nxt = ZERO_BYTE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= ZERO_BYTE;
      REG_ACK_O   <= 1'b0;
    end else begin
      REG_ACK_O <= REG_RD_I || REG_WR_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_nxt;
      end
    end
  end

  sgc_pix_sampler u_pix (
    .clk_i      (MCLK_I),
    .rst_i      (SYS_RST_I),
    .pclk_i     (PCLK_I),
    .pdata_i    (PIX_DATA_I),
    .rise_sel_i (gen_cfg_r[GC_EDGE_SEL]),
    .pix_o      (PIX_O),
    .pix_stb_o  (PIX_STB_O)
  );

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_crc_hold: assert property (gen_cfg_r[GC_CRC_CLR] |=> crc_cnt_r == '0)
    else $error("CRC counter not held clear");
  chk_crc_gate: assert property (!gen_cfg_r[GC_CRC_EN] && !gen_cfg_r[GC_CRC_CLR]
    |=> $stable(crc_cnt_r))
    else $error("CRC counter moved while checker disabled");
  chk_parity_write: assert property (wr_gc
    |=> ##1 PARITY_EN_O == $past(REG_WDATA_I[GC_PARITY_EN], 2))
    else $error("Parity enable does not follow write");
  chk_auto_ack_fire: assert property (REM_WR_REQ_I && auto_ok |=> AUTO_ACK_O && FWD_O)
    else $error("Auto acknowledge missing");
  chk_ack_needs_lock: assert property (AUTO_ACK_O |-> $past(lock_s))
    else $error("Auto acknowledge without lock");
  chk_fwd_remap: assert property (REM_WR_REQ_I && REM_WR_TO_DES_I && gen_cfg_r[GC_FWD_EN]
    |=> FWD_O && FWD_ADDR_O == $past(des_id_r))
    else $error("Forward address not remapped");
  chk_pass_all_scope: assert property (AUTO_ACK_O |-> $past(REM_WR_TO_DES_I)
    || $past(gen_cfg_r[GC_PASS_ALL]))
    else $error("Auto acknowledge for foreign target without pass-all");
  chk_pll_pin: assert property (!gen_cfg_r[GC_PLL_OVR] |=> PLL_SRC_O == $past(mode_s))
    else $error("PLL source does not follow mode pin");
  chk_pll_reg: assert property (gen_cfg_r[GC_PLL_OVR] |=> PLL_SRC_O == $past(PLL_SRC_REG_I))
    else $error("PLL source does not follow override value");
  chk_mode_ovr: assert property (mode_ovr_r |=> MODE12_O == $past(LOCAL_MODE12_I))
    else $error("Local mode not used under override");
  chk_fresh_drop: assert property (!lock_s |=> !fresh_r)
    else $error("Mode shown current without lock");
  chk_des_id_load: assert property (BC_DES_ID_VALID_I && lock_s && !freeze_r && !wr_di
    |=> des_id_r == $past(BC_DES_ID_I))
    else $error("Remote identifier not loaded");
  chk_rsvd_read: assert property (REG_RD_I && REG_ADDR_I == ADDR_RSVD |=> REG_RDATA_O == 8'h00)
    else $error("Reserved register read nonzero");

  cov_auto_ack: cover property (AUTO_ACK_O);
  cov_crc_count: cover property (crc_cnt_r != '0 ##[1:20] crc_cnt_r == '0);
  cov_mode_fresh: cover property (fresh_r && MODE12_O);
  cov_pix_fall: cover property (!gen_cfg_r[GC_EDGE_SEL] && PIX_STB_O);
endmodule

/* File: inc/sgc_pkg.sv */
/*
  Constants shared by the general configuration and mode register slice.
  Assumes one 10 MHz core clock and a register port driven by the local I2C host logic.
*/
// How it works
// - Back-channel CRC errors are counted only while general config bit 7 is set.
// - Forward-channel parity is generated only while general config bit 6 is set.
// - General config bit 5 holds the CRC error counters at zero until cleared.
// - With bits 4 and 2 set, remote writes are acknowledged at once by the device.
// - Auto-acknowledge acts only while the serial link reports lock.
// - Auto-acknowledged writes still go out, those for the deserializer addressed to the identifier at 0x06.
// - Pass-all bit 3 extends auto-acknowledged forwarding to any remote target.
// - With bit 1 set, the PLL clock source comes from the 0x35 register value.
// - With bit 1 clear, the PLL clock source follows the mode pin alone.
// - Bit 0 picks rising (1) or falling (0) pixel clock edge for sampling.
// - Mode select bit 5 makes the local mode setting win over received bits.
// - Mode select bit 4 reads 1 while the received mode information is current.
// - Mode select bit 3 reads 1 exactly when 12-bit high-frequency mode applies.
// - Mode select bit 2 reads 1 exactly when 10-bit mode applies.
// - The remote identifier loads from the back channel under lock unless frozen.
package sgc_pkg;
  localparam logic [7:0] ADDR_GEN_CFG  = 8'h03;
  localparam logic [7:0] ADDR_RSVD     = 8'h04;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h05;
  localparam logic [7:0] ADDR_DES_ID   = 8'h06;

  localparam int GC_CRC_EN    = 7;
  localparam int GC_PARITY_EN = 6;
  localparam int GC_CRC_CLR   = 5;
  localparam int GC_AUTO_ACK  = 4;
  localparam int GC_PASS_ALL  = 3;
  localparam int GC_FWD_EN    = 2;
  localparam int GC_PLL_OVR   = 1;
  localparam int GC_EDGE_SEL  = 0;

  localparam int MS_OVERRIDE  = 5;
  localparam int MS_CURRENT   = 4;
  localparam int MS_MODE12    = 3;
  localparam int MS_MODE10    = 2;

  localparam int DI_FREEZE    = 0;

  localparam logic [7:0] GEN_CFG_RST  = 8'hC5;
  localparam logic [7:0] GEN_CFG_MASK = 8'hFF;
  localparam logic [7:0] MODE_WR_MASK = 8'h20;
  localparam logic [7:0] DES_ID_RST   = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  localparam int CRC_CNT_W = 16;
  localparam int PIX_W     = 12;
  localparam int ID_W      = 7;
endpackage

/* File: src/sgc_pix_sampler.sv */
/*
  Pixel input sampler: brings the pixel clock and pixel bus into the core domain.
  Assumes the pixel clock is much slower than the core clock and the bus is stable
  around the chosen edge.
*/
`timescale 1ns/1ns
module sgc_pix_sampler
  import sgc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             pclk_i,
  input  wire logic [PIX_W-1:0] pdata_i,
  input  wire logic             rise_sel_i,
  output logic      [PIX_W-1:0] pix_o,
  output logic                  pix_stb_o
);
  logic             pclk_s1_r;
  logic             pclk_s2_r;
  logic             pclk_s3_r;
  logic [PIX_W-1:0] pdat_s1_r;
  logic [PIX_W-1:0] pdat_s2_r;
  logic             edge_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
      pdat_s1_r <= '0;
      pdat_s2_r <= '0;
    end else begin
      pclk_s1_r <= pclk_i;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
      pdat_s1_r <= pdata_i;
      pdat_s2_r <= pdat_s1_r;
    end
  end

  // Data and clock share the same synchroniser depth, so the edge lines up with its data.
  assign edge_hit = rise_sel_i ? (pclk_s2_r & ~pclk_s3_r)
                               : (~pclk_s2_r & pclk_s3_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_o     <= '0;
      pix_stb_o <= 1'b0;
    end else begin
      pix_stb_o <= edge_hit;
      if (edge_hit) begin
        pix_o <= pdat_s2_r;
      end
    end
  end
endmodule

/* File: verif/sgc_host_model.sv */
/*
  Local I2C host side model: issues single byte register accesses.
  Assumes the one-cycle strobe and one-cycle acknowledge of the register port.
*/
`timescale 1ns/1ns
module sgc_host_model
  import sgc_pkg::*;
(
  input  wire logic       clk_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       ack_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Strobes last one cycle and acknowledge and read data are taken in the next one.
  // Address and data stay put through the acknowledge cycle and are scrambled afterwards.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = ~w;
    @(negedge clk_i);
    ok = ack_i;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    @(negedge clk_i);
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

/* File: verif/serializer_general_config_mode_regs_bench.sv */
/*
  Self-checking bench for the configuration and mode register slice.
  Assumes a 10 MHz core clock and a pixel clock that is high for 400 ns inside each frame.
*/
`timescale 1ns/1ns
module serializer_general_config_mode_regs_bench
  import sgc_pkg::*;
;
  logic clk, rst, wr, rd, ack, lock, crc_e, crc_en, par_en, rq, rdes, aack, fwd;
  logic mpin, preg, psrc, pclk, stb, bmv, bm12, bm10, lm12, lm10, m12, m10, biv;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] cnt;
  logic [6:0]  raddr, faddr, bid;
  logic [11:0] pdata, pix, last_pix;
  int          failures, tests_run, stb_n;

  sgc_config_regs u_sgc_config_regs (.MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
    .LINK_LOCK_I(lock), .BC_CRC_ERR_I(crc_e), .CRC_ERR_CNT_O(cnt), .CRC_CHECK_EN_O(crc_en),
    .PARITY_EN_O(par_en), .REM_WR_REQ_I(rq), .REM_WR_TO_DES_I(rdes), .REM_WR_ADDR_I(raddr),
    .AUTO_ACK_O(aack), .FWD_O(fwd), .FWD_ADDR_O(faddr), .MODE_PIN_I(mpin),
    .PLL_SRC_REG_I(preg), .PLL_SRC_O(psrc), .PCLK_I(pclk), .PIX_DATA_I(pdata), .PIX_O(pix),
    .PIX_STB_O(stb), .BC_MODE_VALID_I(bmv), .BC_MODE12_I(bm12), .BC_MODE10_I(bm10),
    .LOCAL_MODE12_I(lm12), .LOCAL_MODE10_I(lm10), .MODE12_O(m12), .MODE10_O(m10),
    .BC_DES_ID_VALID_I(biv), .BC_DES_ID_I(bid));
  sgc_host_model u_sgc_host_model (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata), .ack_i(ack));

  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) begin
    last_pix <= pix;
    stb_n <= stb_n + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    u_sgc_host_model.xfer(1'b1, a, d, q, ok);
    chk("write ack", 16'h1, {15'h0, ok});
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    u_sgc_host_model.xfer(1'b0, a, 8'h00, q, ok);
    chk("read ack", 16'h1, {15'h0, ok});
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  task automatic crc_pulse();
    crc_e = 1'b1;
    tick(1);
    crc_e = 1'b0;
    tick(1);
  endtask
  // Sends one remote write and judges the acknowledge and forward pulses.
  task automatic rem_wr(input logic des, input logic ea, input logic ef);
    rq = 1'b1;
    rdes = des;
    tick(1);
    rq = 1'b0;
    chk("auto ack", {15'h0, ea}, {15'h0, aack});
    chk("forward", {15'h0, ef}, {15'h0, fwd});
    tick(1);
  endtask
  task automatic pix_run(input logic rise, input logic [11:0] e);
    int n0;
    wreg(8'h03, {7'h62, rise});
    n0 = stb_n;
    pdata = 12'hA5C;
    tick(2);
    pclk = 1'b1;
    tick(2);
    pdata = 12'h3C3;
    tick(2);
    pclk = 1'b0;
    tick(6);
    chk("pix strobes", 16'h1, 16'(stb_n - n0));
    chk("pix data", {4'h0, e}, {4'h0, last_pix});
  endtask

  task automatic t_reset();
    chk("crc en", 16'h1, {15'h0, crc_en});
    chk("parity en", 16'h1, {15'h0, par_en});
    rreg(8'h03, 8'hC5);
    rreg(8'h05, 8'h00);
    wreg(8'h04, 8'hFF);
    rreg(8'h04, 8'h00);
    rreg(8'h07, 8'h00);
  endtask
  task automatic t_crc();
    repeat (3) crc_pulse();
    chk("crc count", 16'h3, cnt);
    wreg(8'h03, 8'h45);
    tick(1);
    chk("crc en", 16'h0, {15'h0, crc_en});
    crc_pulse();
    chk("crc count off", 16'h3, cnt);
    wreg(8'h03, 8'h85);
    tick(1);
    chk("parity en", 16'h0, {15'h0, par_en});
    wreg(8'h03, 8'hE5);
    tick(1);
    crc_pulse();
    chk("crc cleared", 16'h0, cnt);
    rreg(8'h03, 8'hE5);
    wreg(8'h03, 8'hC5);
  endtask
  task automatic t_pll();
    mpin = 1'b1;
    tick(4);
    chk("pll pin", 16'h1, {15'h0, psrc});
    wreg(8'h03, 8'hC7);
    tick(1);
    chk("pll reg", 16'h0, {15'h0, psrc});
    preg = 1'b1;
    mpin = 1'b0;
    tick(4);
    chk("pll reg", 16'h1, {15'h0, psrc});
    wreg(8'h03, 8'hC5);
    tick(1);
    chk("pll pin", 16'h0, {15'h0, psrc});
  endtask
  task automatic t_remote();
    wreg(8'h03, 8'hD5);
    rem_wr(1'b1, 1'b0, 1'b1);
    lock = 1'b1;
    tick(4);
    bid = 7'h2A;
    biv = 1'b1;
    tick(1);
    biv = 1'b0;
    rem_wr(1'b1, 1'b1, 1'b1);
    chk("fwd addr", 16'h002A, {9'h0, faddr});
    raddr = 7'h33;
    rem_wr(1'b0, 1'b0, 1'b1);
    chk("fwd addr other", 16'h0033, {9'h0, faddr});
    wreg(8'h03, 8'hDD);
    rem_wr(1'b0, 1'b1, 1'b1);
    wreg(8'h06, 8'h23);
    biv = 1'b1;
    tick(1);
    biv = 1'b0;
    rreg(8'h06, 8'h23);
  endtask
  task automatic t_mode();
    bm12 = 1'b1;
    bmv = 1'b1;
    tick(1);
    bmv = 1'b0;
    tick(2);
    rreg(8'h05, 8'h18);
    chk("mode12", 16'h1, {15'h0, m12});
    lm10 = 1'b1;
    wreg(8'h05, 8'hF4);
    tick(2);
    rreg(8'h05, 8'h34);
    chk("mode10", 16'h1, {15'h0, m10});
    lock = 1'b0;
    tick(4);
    rreg(8'h05, 8'h24);
  endtask

  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {rst, lock, crc_e, rq, rdes, mpin, preg, pclk, bmv, bm12, bm10, lm12, lm10, biv} = 14'h2000;
    raddr = 7'h00;
    bid = 7'h00;
    pdata = 12'h000;
    failures = 0;
    tests_run = 0;
    stb_n = 0;
    last_pix = 12'h000;
    tick(2);
    rst = 1'b0;
    tick(1);
    t_reset();
    t_crc();
    t_pll();
    pix_run(1'b1, 12'hA5C);
    pix_run(1'b0, 12'h3C3);
    t_remote();
    t_mode();
    report_and_stop();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
